/* File: include/mmd_bus_if.sv */
// Interface: CPU memory bus between the core end and the decoder end
`timescale 1ns/1ps
`default_nettype none
interface mmd_bus_if;
  import mmd_pkg::*;

  logic         req;
  logic         prog;
  logic         wr;
  logic         wide;
  mmd_addr_type addr;
  logic [31:0]  wdata;
  logic         unlock;
  logic         lock;
  logic         rd_rdy;
  logic         wr_rdy;
  logic         ack;
  logic [31:0]  rdata;

  modport dev (
    input  req, prog, wr, wide, addr, wdata, unlock, lock,
    output rd_rdy, wr_rdy, ack, rdata
  );
  modport cpu (
    output req, prog, wr, wide, addr, wdata, unlock, lock,
    input  rd_rdy, wr_rdy, ack, rdata
  );
endinterface
`default_nettype wire

/* File: include/mmd_pkg.sv */
// Package: address map, region codes, wait-state counts and shared decode helpers
`default_nettype none
package mmd_pkg;

  typedef logic [21:0] mmd_addr_type;

  // Target areas, frame 0 units and flash zones
  typedef enum logic [3:0] {
    MMD_R_NONE, MMD_R_SRAM_M, MMD_R_F0, MMD_R_F1, MMD_R_F2,
    MMD_R_SRAM_L, MMD_R_OTP, MMD_R_FLASH, MMD_R_ROM
  } mmd_region_type;
  typedef enum logic [2:0] {
    MMD_U_NONE, MMD_U_EMU, MMD_U_FLASHCTL, MMD_U_SEC,
    MMD_U_ADCRES, MMD_U_TIMER, MMD_U_INTX, MMD_U_VECT
  } mmd_unit_type;
  typedef enum logic [1:0] {
    MMD_Z_PLAIN, MMD_Z_RESV, MMD_Z_ENTRY, MMD_Z_PASSWORD
  } mmd_zone_type;
  typedef enum logic [1:0] {MMD_C_ACCESS, MMD_C_UNLOCK, MMD_C_LOCK} mmd_cmd_type;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam mmd_addr_type MMD_SRAM_M_LO = 22'h00_0000;
  localparam mmd_addr_type MMD_SRAM_M_HI = 22'h00_07ff;
  localparam mmd_addr_type MMD_F0_LO     = 22'h00_0800;
  localparam mmd_addr_type MMD_F0_HI     = 22'h00_1fff;
  localparam mmd_addr_type MMD_F1_LO     = 22'h00_6000;
  localparam mmd_addr_type MMD_F1_HI     = 22'h00_6fff;
  localparam mmd_addr_type MMD_F2_LO     = 22'h00_7000;
  localparam mmd_addr_type MMD_F2_HI     = 22'h00_7fff;
  localparam mmd_addr_type MMD_SRAM_L_LO = 22'h00_8000;
  localparam mmd_addr_type MMD_SRAM_L_HI = 22'h00_9fff;
  localparam mmd_addr_type MMD_OTP_LO    = 22'h3d_7800;
  localparam mmd_addr_type MMD_OTP_HI    = 22'h3d_7bff;
  localparam mmd_addr_type MMD_FLASH_LO  = 22'h3e_8000;
  localparam mmd_addr_type MMD_FLASH_HI  = 22'h3f_7fff;
  localparam mmd_addr_type MMD_ROM_LO    = 22'h3f_f000;
  localparam mmd_addr_type MMD_ROM_HI    = 22'h3f_ffff;
  // Flash zones at the top of sector A
  localparam mmd_addr_type MMD_RESV_LO   = 22'h3f_7f80;
  localparam mmd_addr_type MMD_DONLY_LO  = 22'h3f_7ff0;
  localparam mmd_addr_type MMD_RESV_HI   = 22'h3f_7ff5;
  localparam mmd_addr_type MMD_ENTRY_LO  = 22'h3f_7ff6;
  localparam mmd_addr_type MMD_ENTRY_HI  = 22'h3f_7ff7;
  localparam mmd_addr_type MMD_PW_LO     = 22'h3f_7ff8;
  localparam mmd_addr_type MMD_PW_HI     = 22'h3f_7fff;
  localparam int           MMD_SECT_SHIFT = 14;

  // ----------------------------------------------------------------
  // Wait states and pipeline lag
  // ----------------------------------------------------------------
  localparam logic [4:0] MMD_WS_ZERO      = 5'h00;
  localparam logic [4:0] MMD_WS_ROM       = 5'h01;
  localparam logic [4:0] MMD_WS_PERIPH_RD = 5'h02;
  localparam logic [4:0] MMD_WS_OTP_MIN   = 5'h01;
  localparam logic [4:0] MMD_WS_PASSWORD  = 5'h10;
  localparam logic [4:0] MMD_WS_F1_HIT    = 5'h01;
  localparam logic [1:0] MMD_WR_LAG       = 2'h2;

  // One decoded access
  typedef struct packed {
    logic           v;
    logic           wr;
    logic           wide;
    mmd_addr_type   addr;
    logic [31:0]    data;
    mmd_region_type region;
    mmd_unit_type   unit;
    mmd_zone_type   zone;
    logic [1:0]     sector;
    logic [4:0]     ws;
  } mmd_op_type;

  function automatic logic mmd_in(mmd_addr_type a, mmd_addr_type lo, mmd_addr_type hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // Frame 0 unit lookup; gaps give none
  function automatic mmd_unit_type mmd_f0_unit(mmd_addr_type a);
    mmd_unit_type u;
    u = MMD_U_NONE;
    if (mmd_in(a, 22'h00_0880, 22'h00_09ff)) u = MMD_U_EMU;
    else if (mmd_in(a, 22'h00_0a80, 22'h00_0adf)) u = MMD_U_FLASHCTL;
    else if (mmd_in(a, 22'h00_0ae0, 22'h00_0aef)) u = MMD_U_SEC;
    else if (mmd_in(a, 22'h00_0b00, 22'h00_0b0f)) u = MMD_U_ADCRES;
    else if (mmd_in(a, 22'h00_0c00, 22'h00_0c3f)) u = MMD_U_TIMER;
    else if (mmd_in(a, 22'h00_0ce0, 22'h00_0cff)) u = MMD_U_INTX;
    else if (mmd_in(a, 22'h00_0d00, 22'h00_0dff)) u = MMD_U_VECT;
    return u;
  endfunction

endpackage
`default_nettype wire

/* File: logic/mmd_cpu_host.sv */
// CPU end: issues memory accesses and lock commands, screens software misuse
`timescale 1ns/1ps
`default_nettype none
module mmd_cpu_host
  import mmd_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rstn,
  mmd_bus_if.cpu             bus,
  input  wire logic          pw_programmed,
  input  wire logic          cmd_valid,
  input  wire mmd_cmd_type   cmd_op,
  input  wire logic          cmd_prog,
  input  wire logic          cmd_wr,
  input  wire logic          cmd_wide,
  input  wire mmd_addr_type  cmd_addr,
  input  wire logic [31:0]   cmd_wdata,
  output logic               cmd_ready,
  output logic               resp_valid,
  output logic               resp_err,
  output logic [31:0]        resp_data
);

  typedef enum {MMD_H_IDLE, MMD_H_REQ, MMD_H_WAIT} mmd_host_st_type;

  typedef struct packed {
    mmd_host_st_type st;
    logic            rdy;
    logic            req;
    logic            prog;
    logic            wr;
    logic            wide;
    mmd_addr_type    addr;
    logic [31:0]     wdata;
    logic            unlock;
    logic            lock;
    logic            rv;
    logic            err;
    logic [31:0]     rdata;
    logic [7:0]      pw_zero;
  } mmd_host_state_type;

  localparam mmd_host_state_type S_RST = '{st: MMD_H_IDLE, rdy: 1'b1, default: '0};

  mmd_host_state_type s_q;
  mmd_host_state_type s_d;
  logic               refuse;
  logic [7:0]         pw_bit;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    s_d.rv     = 1'b0;
    s_d.unlock = 1'b0;
    s_d.lock   = 1'b0;
    pw_bit     = 8'h01 << cmd_addr[2:0];
    refuse     = 1'b0;
    // Software misuse that never reaches the bus
    if (mmd_in(cmd_addr, MMD_F0_LO, MMD_F0_HI) && mmd_f0_unit(cmd_addr) == MMD_U_NONE) begin
      refuse = 1'b1;
    end
    if (pw_programmed && mmd_in(cmd_addr, MMD_RESV_LO, MMD_RESV_HI) &&
        !(cmd_wr && cmd_wdata[15:0] == 16'h0000)) begin
      refuse = 1'b1;
    end
    if (!pw_programmed && cmd_prog && !cmd_wr &&
        mmd_in(cmd_addr, MMD_DONLY_LO, MMD_RESV_HI)) begin
      refuse = 1'b1;
    end
    if (cmd_wr && mmd_in(cmd_addr, MMD_PW_LO, MMD_PW_HI) && cmd_wdata[15:0] == 16'h0000 &&
        (s_q.pw_zero | pw_bit) == 8'hff) begin
      refuse = 1'b1;
    end
    unique case (s_q.st)
      MMD_H_IDLE: begin
        if (cmd_valid && s_q.rdy) begin
          if (cmd_op == MMD_C_UNLOCK) begin
            s_d.unlock = 1'b1;
            s_d.rv     = 1'b1;
            s_d.err    = 1'b0;
          end else if (cmd_op == MMD_C_LOCK) begin
            s_d.lock = 1'b1;
            s_d.rv   = 1'b1;
            s_d.err  = 1'b0;
          end else if (refuse) begin
            s_d.rv  = 1'b1;
            s_d.err = 1'b1;
          end else begin
            s_d.rdy   = 1'b0;
            s_d.req   = 1'b1;
            s_d.prog  = cmd_prog;
            s_d.wr    = cmd_wr;
            s_d.wide  = cmd_wide;
            s_d.addr  = cmd_addr;
            s_d.wdata = cmd_wdata;
            s_d.st    = MMD_H_REQ;
            if (cmd_wr && mmd_in(cmd_addr, MMD_PW_LO, MMD_PW_HI)) begin
              s_d.pw_zero = cmd_wdata[15:0] == 16'h0000 ? (s_q.pw_zero | pw_bit)
                                                        : (s_q.pw_zero & ~pw_bit);
            end
          end
        end
      end
      MMD_H_REQ: begin
        // Request taken on a ready edge
        if (s_q.wr ? bus.wr_rdy : bus.rd_rdy) begin
          s_d.req = 1'b0;
          s_d.st  = MMD_H_WAIT;
        end
      end
      MMD_H_WAIT: begin
        if (bus.ack) begin
          s_d.rv    = 1'b1;
          s_d.err   = 1'b0;
          s_d.rdata = s_q.wr ? 32'h0000_0000 : bus.rdata;
          s_d.rdy   = 1'b1;
          s_d.st    = MMD_H_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign bus.req    = s_q.req;
  assign bus.prog   = s_q.prog;
  assign bus.wr     = s_q.wr;
  assign bus.wide   = s_q.wide;
  assign bus.addr   = s_q.addr;
  assign bus.wdata  = s_q.wdata;
  assign bus.unlock = s_q.unlock;
  assign bus.lock   = s_q.lock;
  assign cmd_ready  = s_q.rdy;
  assign resp_valid = s_q.rv;
  assign resp_err   = s_q.err;
  assign resp_data  = s_q.rdata;

endmodule
`default_nettype wire

/* File: logic/mmd_decoder_dev.sv */
// Memory map decoder: area select, access control, ordering and wait states
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder_dev
  import mmd_pkg::*;
#(
  parameter int WS_W = 4
) (
  input  wire logic            clock,
  input  wire logic            rstn,
  mmd_bus_if.dev               bus,
  input  wire logic [WS_W-1:0] flash_ws,
  input  wire logic [WS_W-1:0] otp_ws,
  input  wire logic            secured,
  input  wire logic            order_prot_en,
  input  wire logic [31:0]     tgt_rdata,
  output logic                 tgt_req,
  output logic                 tgt_wr,
  output logic                 tgt_wide,
  output var mmd_addr_type     tgt_addr,
  output logic [31:0]          tgt_wdata,
  output var mmd_region_type   tgt_region,
  output var mmd_unit_type     tgt_unit,
  output var mmd_zone_type     tgt_zone,
  output logic [1:0]           tgt_sector,
  output logic                 wr_unlocked
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (WS_W < 1 || WS_W > 4) begin : g_bad_ws
    $error("WS_W must lie between 1 and 4");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mmd_op_type  cur;
    mmd_op_type  rd;
    mmd_op_type  wp;
    logic [4:0]  cnt;
    logic [1:0]  lag;
    logic        f1_hit;
    logic        unlock;
    logic        req_p;
    logic        ack;
    logic [31:0] rdata;
    logic        rd_rdy;
    logic        wr_rdy;
  } mmd_dev_state_type;

  localparam mmd_dev_state_type S_RST = '{rd_rdy: 1'b1, wr_rdy: 1'b1, default: '0};

  mmd_dev_state_type s_q;
  mmd_dev_state_type s_d;
  mmd_op_type        inc;
  mmd_op_type        rd_c;
  mmd_op_type        nxt;
  logic              take_rd;
  logic              take_wr;
  logic              rd_used;
  logic              ordered;

  // ----------------------------------------------------------------
  // Address decode of one access
  // ----------------------------------------------------------------
  function automatic mmd_op_type decode(
    input logic            prog,
    input logic            wr,
    input logic            wide,
    input mmd_addr_type    a,
    input logic [31:0]     d,
    input logic            unl,
    input logic            sec,
    input logic [WS_W-1:0] fws,
    input logic [WS_W-1:0] ows
  );
    mmd_op_type o;
    logic [4:0] per_ws;
    o        = '0;
    o.v      = 1'b1;
    o.wr     = wr;
    o.wide   = wide;
    o.addr   = a;
    o.data   = d;
    per_ws   = wr ? MMD_WS_ZERO : MMD_WS_PERIPH_RD;
    if (mmd_in(a, MMD_SRAM_M_LO, MMD_SRAM_M_HI)) begin
      o.region = MMD_R_SRAM_M;
    end else if (mmd_in(a, MMD_F0_LO, MMD_F0_HI) && !prog) begin
      o.unit = mmd_f0_unit(a);
      if (o.unit != MMD_U_NONE) begin
        o.region = MMD_R_F0;
      end
      if (o.unit == MMD_U_FLASHCTL && sec) begin
        o.region = MMD_R_NONE;
      end
      if (wr && !unl && o.unit inside {MMD_U_EMU, MMD_U_FLASHCTL, MMD_U_SEC, MMD_U_VECT}) begin
        o.region = MMD_R_NONE;
      end
    end else if (mmd_in(a, MMD_F1_LO, MMD_F1_HI) && !prog) begin
      o.region = MMD_R_F1;
      o.ws     = per_ws;
    end else if (mmd_in(a, MMD_F2_LO, MMD_F2_HI) && !prog && !wide) begin
      o.region = MMD_R_F2;
      o.ws     = per_ws;
    end else if (mmd_in(a, MMD_SRAM_L_LO, MMD_SRAM_L_HI)) begin
      o.region = MMD_R_SRAM_L;
    end else if (mmd_in(a, MMD_OTP_LO, MMD_OTP_HI)) begin
      o.region = MMD_R_OTP;
      o.ws     = (5'(ows) < MMD_WS_OTP_MIN) ? MMD_WS_OTP_MIN : 5'(ows);
    end else if (mmd_in(a, MMD_FLASH_LO, MMD_FLASH_HI)) begin
      o.region = MMD_R_FLASH;
      o.sector = 2'((a - MMD_FLASH_LO) >> MMD_SECT_SHIFT);
      o.ws     = 5'(fws);
      if (mmd_in(a, MMD_PW_LO, MMD_PW_HI)) begin
        o.zone = MMD_Z_PASSWORD;
        o.ws   = MMD_WS_PASSWORD;
      end else if (mmd_in(a, MMD_ENTRY_LO, MMD_ENTRY_HI)) begin
        o.zone = MMD_Z_ENTRY;
      end else if (mmd_in(a, MMD_RESV_LO, MMD_RESV_HI)) begin
        o.zone = MMD_Z_RESV;
      end
    end else if (mmd_in(a, MMD_ROM_LO, MMD_ROM_HI)) begin
      o.region = MMD_R_ROM;
      o.ws     = MMD_WS_ROM;
    end
    if (o.region == MMD_R_NONE) begin
      o.unit = MMD_U_NONE;
      o.ws   = MMD_WS_ZERO;
    end
    return o;
  endfunction

  // Frames 1 and 2 share one ordering zone
  function automatic logic in_prot_zone(mmd_op_type o);
    return o.region inside {MMD_R_F1, MMD_R_F2};
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_d     = s_q;
    inc     = decode(bus.prog, bus.wr, bus.wide, bus.addr, bus.wdata,
                     s_q.unlock, secured, flash_ws, otp_ws);
    take_rd = bus.req && !bus.wr && s_q.rd_rdy;
    take_wr = bus.req && bus.wr && s_q.wr_rdy;
    rd_used = 1'b0;
    ordered = 1'b0;
    rd_c    = '0;
    nxt     = '0;
    s_d.ack   = 1'b0;
    s_d.req_p = 1'b0;
    // Write lock wins over unlock in the same cycle
    if (bus.lock) begin
      s_d.unlock = 1'b0;
    end else if (bus.unlock) begin
      s_d.unlock = 1'b1;
    end
    // Posted write ages toward its write stage
    if (s_q.wp.v && s_q.lag != 2'h0) begin
      s_d.lag = s_q.lag - 2'h1;
    end
    if (s_q.cur.v) begin
      // Count down waits, finish on zero
      if (s_q.cnt == MMD_WS_ZERO) begin
        s_d.cur.v  = 1'b0;
        s_d.f1_hit = s_q.cur.wr && s_q.cur.region == MMD_R_F1;
        if (!s_q.cur.wr) begin
          s_d.ack   = 1'b1;
          s_d.rdata = (s_q.cur.region == MMD_R_NONE) ? 32'h0000_0000 : tgt_rdata;
        end
      end else begin
        s_d.cnt = s_q.cnt - 5'h01;
      end
    end else begin
      // Pick the next access; the frame 1 write mark lasts until one leaves
      rd_c = s_q.rd.v ? s_q.rd : (take_rd ? inc : '0);
      ordered = s_q.wp.v && rd_c.v && ((order_prot_en &&
                (in_prot_zone(s_q.wp) || in_prot_zone(rd_c))) ||
                s_q.wp.addr == rd_c.addr);
      if (s_q.wp.v && (ordered || (!rd_c.v && s_q.lag == 2'h0))) begin
        nxt      = s_q.wp;
        s_d.wp.v = 1'b0;
      end else if (rd_c.v) begin
        nxt = rd_c;
        if (s_q.rd.v) begin
          s_d.rd.v = 1'b0;
        end else begin
          rd_used = 1'b1;
        end
      end
      if (nxt.v) begin
        s_d.cur   = nxt;
        s_d.cnt   = nxt.ws;
        s_d.f1_hit = 1'b0;
        if (nxt.wr && nxt.region == MMD_R_F1 && s_q.f1_hit) begin
          s_d.cnt = 5'(nxt.ws + MMD_WS_F1_HIT);
        end
        s_d.req_p = nxt.region != MMD_R_NONE;
      end
    end
    // Accepted read waits its turn
    if (take_rd && !rd_used) begin
      s_d.rd = inc;
    end
    // Writes are posted and acknowledged at once; dropped ones too
    if (take_wr) begin
      s_d.ack = 1'b1;
      if (inc.region != MMD_R_NONE) begin
        s_d.wp  = inc;
        s_d.lag = MMD_WR_LAG;
      end
    end
    s_d.wr_rdy = !s_d.wp.v;
    s_d.rd_rdy = !s_d.rd.v && !(s_d.cur.v && !s_d.cur.wr);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign bus.rd_rdy  = s_q.rd_rdy;
  assign bus.wr_rdy  = s_q.wr_rdy;
  assign bus.ack     = s_q.ack;
  assign bus.rdata   = s_q.rdata;
  assign tgt_req     = s_q.req_p;
  assign tgt_wr      = s_q.cur.wr;
  assign tgt_wide    = s_q.cur.wide;
  assign tgt_addr    = s_q.cur.addr;
  assign tgt_wdata   = s_q.cur.data;
  assign tgt_region  = s_q.cur.region;
  assign tgt_unit    = s_q.cur.unit;
  assign tgt_zone    = s_q.cur.zone;
  assign tgt_sector  = s_q.cur.sector;
  assign wr_unlocked = s_q.unlock;

endmodule
`default_nettype wire

/* File: tb/memory_map_decode_waitstates_tb.sv */
// Testbench: host and decoder joined by the bus, driven from the host command side
`timescale 1ns/1ps
`default_nettype none
module memory_map_decode_waitstates_tb;
  import mmd_pkg::*;
  logic         clock;
  logic         rstn;
  logic         pw_programmed;
  logic         secured;
  logic         order_prot_en;
  logic         cmd_valid;
  mmd_cmd_type  cmd_op;
  logic         cmd_prog;
  logic         cmd_wr;
  logic         cmd_wide;
  mmd_addr_type cmd_addr;
  logic         cmd_ready;
  logic         resp_valid;
  logic         resp_err;
  logic [31:0]  resp_data;
  logic         tgt_req;
  mmd_addr_type tgt_addr;
  mmd_addr_type tgt_prev;
  mmd_addr_type tgt_last;
  logic [1:0]   tgt_sector;
  logic         wr_unlocked;
  int           bad_count = 0;
  int           checks = 0;
  int           tgt_n = 0;
  mmd_bus_if i_mmd_bus_if ();
  mmd_decoder_dev i_mmd_decoder_dev (.clock(clock), .rstn(rstn), .bus(i_mmd_bus_if),
    .flash_ws(4'h2), .otp_ws(4'h0), .secured(secured), .order_prot_en(order_prot_en),
    .tgt_rdata({10'h000, tgt_addr}), .tgt_req(tgt_req), .tgt_wr(), .tgt_wide(),
    .tgt_addr(tgt_addr), .tgt_wdata(), .tgt_region(), .tgt_unit(), .tgt_zone(),
    .tgt_sector(tgt_sector), .wr_unlocked(wr_unlocked));
  mmd_cpu_host i_mmd_cpu_host (.clock(clock), .rstn(rstn), .bus(i_mmd_bus_if),
    .pw_programmed(pw_programmed), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_prog(cmd_prog), .cmd_wr(cmd_wr), .cmd_wide(cmd_wide), .cmd_addr(cmd_addr),
    .cmd_wdata(32'h0000_5a5a), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
    .resp_err(resp_err), .resp_data(resp_data));
  mmd_bus_checker i_mmd_bus_checker (.clock(clock), .rstn(rstn),
    .req(i_mmd_bus_if.req), .prog(i_mmd_bus_if.prog), .wr(i_mmd_bus_if.wr),
    .wide(i_mmd_bus_if.wide), .addr(i_mmd_bus_if.addr), .unlock(i_mmd_bus_if.unlock),
    .rd_rdy(i_mmd_bus_if.rd_rdy), .wr_rdy(i_mmd_bus_if.wr_rdy), .ack(i_mmd_bus_if.ack),
    .rdata(i_mmd_bus_if.rdata));
  // Clock and count of target accesses
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (tgt_req === 1'b1) begin
      tgt_n    <= tgt_n + 1;
      tgt_prev <= tgt_last;
      tgt_last <= tgt_addr;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      bad_count++;
    end
  endtask
  // One command: error, read data and number of target accesses it caused
  task automatic t(input mmd_cmd_type op, input logic p, w, wd, input mmd_addr_type a,
                   input logic ee, ok, input int en);
    int n0;
    int k;
    n0 = tgt_n;
    k = 0;
    cmd_op = op;
    {cmd_prog, cmd_wr, cmd_wide} = {p, w, wd};
    cmd_addr = a;
    cmd_valid = 1'b1;
    @(posedge clock);
    #1 cmd_valid = 1'b0;
    while (resp_valid !== 1'b1 && k < 60) begin
      @(posedge clock);
      #1 k++;
    end
    chk("resp", 32'h0000_0001, {31'h0, resp_valid});
    chk("err", {31'h0, ee}, {31'h0, resp_err});
    if (op == MMD_C_ACCESS && !ee) chk("data", (w || !ok) ? 32'h0000_0000 : {10'h000, a}, resp_data);
    repeat (4) @(posedge clock);
    #1 chk("tgt", 32'(en), 32'(tgt_n - n0));
    $display("test %h done", a);
  endtask
  // Write, then a read at once: read latency in cycles and target issue order
  task automatic wr_rd(input mmd_addr_type aw, ar, input logic wf, input int ek);
    int n0;
    int k;
    n0 = tgt_n;
    k = 0;
    cmd_op = MMD_C_ACCESS;
    {cmd_prog, cmd_wr, cmd_wide} = 3'b010;
    cmd_addr = aw;
    cmd_valid = 1'b1;
    @(posedge clock);
    #1 cmd_valid = 1'b0;
    while (resp_valid !== 1'b1 && k < 60) begin
      @(posedge clock);
      #1 k++;
    end
    cmd_wr = 1'b0;
    cmd_addr = ar;
    cmd_valid = 1'b1;
    k = 0;
    @(posedge clock);
    #1 cmd_valid = 1'b0;
    while (resp_valid !== 1'b1 && k < 60) begin
      @(posedge clock);
      #1 k++;
    end
    chk("lat", 32'(ek), 32'(k));
    chk("data", {10'h000, ar}, resp_data);
    repeat (4) @(posedge clock);
    #1 chk("tgt", 32'h0000_0002, 32'(tgt_n - n0));
    chk("first", {10'h000, wf ? aw : ar}, {10'h000, tgt_prev});
    $display("order %h %h done", aw, ar);
  endtask
  task automatic finish_test;
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    bad_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    {rstn, pw_programmed, secured, cmd_valid, cmd_prog, cmd_wr, cmd_wide} = 7'h00;
    cmd_op = MMD_C_ACCESS;
    cmd_addr = 22'h00_0000;
    order_prot_en = 1'b1;
    repeat (8) @(posedge clock);
    #1 rstn = 1'b1;
    t(MMD_C_ACCESS, 0, 0, 0, 22'h00_0123, 0, 1, 1);
    for (int j = 0; j < 4; j++) begin
      t(MMD_C_ACCESS, 0, 0, 0, MMD_FLASH_LO + (22'(j) << MMD_SECT_SHIFT), 0, 1, 1);
      chk("sector", 32'(j), {30'h0, tgt_sector});
    end
    t(MMD_C_ACCESS, 0, 0, 0, 22'h3f_7f7f, 0, 1, 1);
    chk("sector", 32'h0000_0003, {30'h0, tgt_sector});
    t(MMD_C_ACCESS, 1, 0, 0, 22'h3f_f010, 0, 1, 1);
    t(MMD_C_ACCESS, 0, 0, 0, 22'h3d_7800, 0, 1, 1);
    t(MMD_C_ACCESS, 0, 0, 0, MMD_PW_LO, 0, 1, 1);
    t(MMD_C_ACCESS, 1, 0, 0, MMD_ENTRY_LO, 0, 1, 1);
    t(MMD_C_ACCESS, 1, 0, 0, 22'h00_6010, 0, 0, 0);
    t(MMD_C_ACCESS, 1, 1, 0, 22'h00_6010, 0, 0, 0);
    t(MMD_C_ACCESS, 0, 0, 0, 22'h00_6010, 0, 1, 1);
    t(MMD_C_ACCESS, 0, 0, 1, 22'h00_7010, 0, 0, 0);
    t(MMD_C_ACCESS, 0, 0, 0, 22'h00_7010, 0, 1, 1);
    t(MMD_C_ACCESS, 0, 0, 0, 22'h00_4000, 0, 0, 0);
    t(MMD_C_ACCESS, 0, 1, 0, 22'h00_4000, 0, 0, 0);
    t(MMD_C_ACCESS, 0, 0, 1, 22'h00_0c00, 0, 1, 1);
    t(MMD_C_ACCESS, 0, 0, 0, 22'h00_0a00, 1, 0, 0);
    t(MMD_C_ACCESS, 0, 1, 0, 22'h00_0d00, 0, 0, 0);
    t(MMD_C_ACCESS, 0, 1, 0, 22'h00_0c00, 0, 0, 1);
    t(MMD_C_UNLOCK, 0, 0, 0, 22'h00_0000, 0, 0, 0);
    chk("unlocked", 32'h0000_0001, {31'h0, wr_unlocked});
    t(MMD_C_ACCESS, 0, 1, 0, 22'h00_0d00, 0, 0, 1);
    secured = 1'b1;
    t(MMD_C_ACCESS, 0, 1, 0, 22'h00_0a80, 0, 0, 0);
    t(MMD_C_ACCESS, 0, 0, 0, 22'h00_0a80, 0, 0, 0);
    secured = 1'b0;
    t(MMD_C_ACCESS, 0, 1, 0, 22'h00_0a80, 0, 0, 1);
    t(MMD_C_LOCK, 0, 0, 0, 22'h00_0000, 0, 0, 0);
    chk("unlocked", 32'h0000_0000, {31'h0, wr_unlocked});
    t(MMD_C_ACCESS, 0, 1, 0, 22'h00_0d00, 0, 0, 0);
    t(MMD_C_ACCESS, 1, 0, 0, 22'h3f_7ff0, 1, 0, 0);
    t(MMD_C_ACCESS, 0, 0, 0, 22'h3f_7ff0, 0, 1, 1);
    pw_programmed = 1'b1;
    t(MMD_C_ACCESS, 0, 0, 0, MMD_RESV_LO, 1, 0, 0);
    wr_rd(22'h00_0200, 22'h00_0300, 0, 3);
    wr_rd(22'h00_0200, 22'h00_0200, 1, 5);
    wr_rd(22'h00_6100, 22'h00_6200, 1, 7);
    wr_rd(22'h00_7100, 22'h00_7200, 1, 7);
    order_prot_en = 1'b0;
    wr_rd(22'h00_6100, 22'h00_6200, 0, 5);
    order_prot_en = 1'b1;
    wr_rd(22'h00_6104, 22'h00_0300, 1, 6);
    finish_test();
  end
endmodule
`default_nettype wire

/* File: tb/mmd_bus_checker.sv */
// Checker: timing and data relations on the CPU memory bus
`timescale 1ns/1ps
`default_nettype none
module mmd_bus_checker
  import mmd_pkg::*;
(
  input wire logic         clock,
  input wire logic         rstn,
  input wire logic         req,
  input wire logic         prog,
  input wire logic         wr,
  input wire logic         wide,
  input wire mmd_addr_type addr,
  input wire logic         unlock,
  input wire logic         rd_rdy,
  input wire logic         wr_rdy,
  input wire logic         ack,
  input wire logic [31:0]  rdata
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  logic rd_t;
  logic wr_t;
  logic rd_i;
  // Requests taken by the decoder end
  assign rd_t = req && !wr && rd_rdy;
  assign wr_t = req && wr && wr_rdy;
  // Reads taken with no posted write ahead of them
  assign rd_i = rd_t && wr_rdy;
  a_write_ack_next: assert property (wr_t |=> ack)
    else $error("write not acked next cycle");
  a_sram_zero_wait: assert property (rd_i && addr <= MMD_SRAM_M_HI |=> !ack ##1 ack)
    else $error("small sram read latency wrong");
  a_rom_one_wait: assert property (rd_i && addr >= MMD_ROM_LO |=> !ack[*2] ##1 ack)
    else $error("rom read latency wrong");
  a_frame_read_wait: assert property (rd_i && !prog && addr >= MMD_F1_LO && addr <= MMD_F2_HI
    && !(wide && addr >= MMD_F2_LO) |=> !ack[*3] ##1 ack)
    else $error("frame 1 or 2 read latency wrong");
  a_pw_fixed_wait: assert property (rd_i && addr >= MMD_PW_LO && addr <= MMD_PW_HI
    |=> !ack[*8] ##1 !ack[*8] ##1 !ack ##1 ack)
    else $error("password read latency wrong");
  a_prog_frame_zero: assert property (rd_t && prog && addr >= MMD_F0_LO && addr <= MMD_F2_HI
    |-> ##[2:4] (ack && rdata == 32'h0000_0000))
    else $error("program space frame read not zero");
  a_wide_narrow_zero: assert property (rd_t && wide && addr >= MMD_F2_LO && addr <= MMD_F2_HI
    |-> ##[2:4] (ack && rdata == 32'h0000_0000))
    else $error("wide frame 2 read not zero");
  a_unmapped_read_zero: assert property (rd_t && addr > MMD_F0_HI && addr < MMD_F1_LO
    |-> ##[2:4] (ack && rdata == 32'h0000_0000))
    else $error("unmapped read not zero");
  a_unlock_pulse: assert property (unlock |=> !unlock)
    else $error("unlock longer than one cycle");
  c_pw_read: cover property (rd_t && addr >= MMD_PW_LO);
  c_write: cover property (wr_t);
  c_unlock: cover property (unlock);
  c_read_behind_write: cover property (rd_t && !wr_rdy);
endmodule
`default_nettype wire
